// *** dv/cpu_bus_model.sv ***
// Register bus master standing in for the processor core.
module cpu_bus_model
(
  input wire logic i_clk,
  input wire logic i_pready,
  input wire logic i_pslverr,
  input wire logic [31:0] i_prdata,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end
  // Released address and data lines show the inverse so stale values cannot pass.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    @(posedge i_clk);
    while (i_pready !== 1'b1)
      @(posedge i_clk);
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask : xfer
  task automatic nops();
    repeat (2) @(posedge i_clk);
  endtask : nops
endmodule : cpu_bus_model

// *** dv/self_program_memory_access_asserts.sv ***
// Port-level assertions for the self-programming memory access controller.
module self_program_memory_access_asserts
  import nvm_access_pkg::*;
#(
  parameter int PROGRAM_CYCLES_P = 10
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_cpu_stall,
  input wire logic o_write_done_flag
);
  logic acc;
  logic ctl_wr;
  logic [2:0] trig_age;
  logic [15:0] stall_cnt;
  logic dl_ok;
  logic [31:0] dl_val;
  assign acc = i_psel & i_penable;
  assign ctl_wr = acc & i_pwrite & (i_paddr == CONTROL_OFS);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Age of the last write trigger, so the setup gap before a stall can be measured.
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      trig_age <= 3'h7;
    else if (ctl_wr && i_pwdata[CTL_WRITE_BIT])
      trig_age <= 3'h0;
    else if (trig_age != 3'h7)
      trig_age <= trig_age + 3'h1;
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      stall_cnt <= 16'h0;
    else
      stall_cnt <= o_cpu_stall ? stall_cnt + 16'h1 : 16'h0;
  // Last data low value read back, valid until a read trigger or a software write.
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      dl_ok <= 1'b0;
    else if ((ctl_wr && i_pwdata[CTL_READ_BIT]) || (acc && i_pwrite && i_paddr == DATA_LOW_OFS))
      dl_ok <= 1'b0;
    else if (acc && !i_pwrite && i_paddr == DATA_LOW_OFS)
      dl_ok <= 1'b1;
  always_ff @(posedge i_clk)
    if (acc && !i_pwrite && i_paddr == DATA_LOW_OFS)
      dl_val <= o_prdata;
  property p_ready;
    acc |-> o_pready;
  endproperty
  property p_unmapped;
    acc && i_paddr > STATUS_OFS |-> o_pslverr;
  endproperty
  property p_unlock_zero;
    acc && !i_pwrite && i_paddr == UNLOCK_OFS |-> o_prdata == 32'h0;
  endproperty
  property p_done_sticky;
    o_write_done_flag && !(acc && i_pwrite && i_paddr == STATUS_OFS && i_pwdata[STS_DONE_BIT])
      |=> o_write_done_flag;
  endproperty
  property p_done_at_end;
    $fell(o_cpu_stall) |-> ##[0:2] o_write_done_flag;
  endproperty
  property p_setup_age;
    $rose(o_cpu_stall) |-> trig_age inside {3'h2, 3'h3};
  endproperty
  property p_stall_len;
    $fell(o_cpu_stall) |-> stall_cnt == 16'(PROGRAM_CYCLES_P);
  endproperty
  property p_dl_hold;
    acc && !i_pwrite && i_paddr == DATA_LOW_OFS && dl_ok |-> o_prdata == dl_val;
  endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
  a_unlock_zero: assert property (p_unlock_zero) else $error("unlock port read not zero");
  a_done_sticky: assert property (p_done_sticky) else $error("done flag dropped");
  a_done_at_end: assert property (p_done_at_end) else $error("no done flag");
  a_setup_age: assert property (p_setup_age) else $error("setup gap wrong");
  a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
  a_dl_hold: assert property (p_dl_hold) else $error("data low changed");
  c_stall: cover property ($rose(o_cpu_stall));
  c_done: cover property ($rose(o_write_done_flag));
  c_err: cover property (acc && o_pslverr);
endmodule : self_program_memory_access_asserts

bind self_program_memory_access self_program_memory_access_asserts
  #(.PROGRAM_CYCLES_P(PROGRAM_CYCLES_P)) i_self_program_memory_access_asserts (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_cpu_stall(o_cpu_stall),
  .o_write_done_flag(o_write_done_flag));

// *** dv/tb_top.sv ***
// Self-checking testbench for the self-programming memory access controller.
module tb_top
  import nvm_access_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk;
  logic rstn;
  logic psel;
  logic pen;
  logic pwr;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic stall;
  logic done;
  logic [1:0] wpf;
  logic cp;
  logic wip;
  int failures = 0;
  int num_checks = 0;
  cpu_bus_model i_cpu (.i_clk(clk), .i_pready(pready), .i_pslverr(pslverr),
    .i_prdata(prdata), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr),
    .o_paddr(paddr), .o_pwdata(pwdata));
  self_program_memory_access #(.PROGRAM_CYCLES_P(10)) i_self_program_memory_access (
    .i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_self_write_protect_field(wpf), .i_data_code_protect(cp),
    .i_write_in_progress_at_reset(wip), .o_cpu_stall(stall), .o_write_done_flag(done));
  // ************************************************************
  // Bus and checking helpers
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    i_cpu.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    i_cpu.xfer(1'b0, a, 32'h0, q, e);
  endtask : rd
  // Control word without the trigger first, then both patterns and the trigger with nothing in between.
  task automatic unlock_trig(input logic [31:0] ctl);
    wr(CONTROL_OFS, ctl & ~32'h2);
    wr(UNLOCK_OFS, {24'h0, UNLOCK_FIRST});
    wr(UNLOCK_OFS, {24'h0, UNLOCK_SECOND});
    wr(CONTROL_OFS, ctl);
    i_cpu.nops();
  endtask : unlock_trig
  task automatic wait_write(output logic saw);
    logic [31:0] q;
    saw = 1'b0;
    for (int n = 0; n < 100; n++)
    begin
      rd(CONTROL_OFS, q);
      saw |= stall;
      if (q[CTL_WRITE_BIT] === 1'b0)
        break;
    end
    chk(q & 32'h2, 32'h0);
  endtask : wait_write
  task automatic frd(input logic [7:0] a, output logic [31:0] w);
    logic [31:0] lo;
    logic [31:0] hi;
    wr(ADDR_LOW_OFS, {24'h0, a});
    wr(CONTROL_OFS, 32'h85);
    i_cpu.nops();
    rd(DATA_LOW_OFS, lo);
    rd(DATA_HIGH_OFS, hi);
    w = {16'h0, hi[7:0], lo[7:0]};
  endtask : frd
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rd(CONTROL_OFS, q);
    chk(q, {24'h0, CONTROL_RESET});
    rd(ADDR_LOW_OFS, q);
    chk(q, {24'h0, ADDR_RESET});
    rd(UNLOCK_OFS, q);
    chk(q, 32'h0);
    i_cpu.xfer(1'b0, 8'h40, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
  endtask : t_reset
  task automatic t_eeprom();
    logic [31:0] q;
    logic saw;
    wr(ADDR_LOW_OFS, 32'h21);
    wr(DATA_LOW_OFS, 32'h5A);
    unlock_trig(32'h06);
    wait_write(saw);
    chk({31'h0, done}, 32'h1);
    rd(STATUS_OFS, q);
    chk(q & 32'h1, 32'h1);
    wr(STATUS_OFS, 32'h1);
    rd(STATUS_OFS, q);
    chk(q & 32'h1, 32'h0);
    rd(CONTROL_OFS, q);
    chk(q & 32'h4, 32'h4);
    wr(DATA_LOW_OFS, 32'h33);
    unlock_trig(32'h02);
    rd(CONTROL_OFS, q);
    chk(q & 32'h2, 32'h0);
    wr(CONTROL_OFS, 32'h06);
    wr(UNLOCK_OFS, {24'h0, UNLOCK_FIRST});
    wr(ADDR_LOW_OFS, 32'h21);
    wr(UNLOCK_OFS, {24'h0, UNLOCK_SECOND});
    wr(CONTROL_OFS, 32'h06);
    rd(CONTROL_OFS, q);
    chk(q & 32'h2, 32'h0);
    wr(CONTROL_OFS, 32'h05);
    rd(DATA_LOW_OFS, q);
    chk(q & 32'hFF, 32'h5A);
    rd(DATA_LOW_OFS, q);
    chk(q & 32'hFF, 32'h5A);
    rd(CONTROL_OFS, q);
    chk(q & 32'h1, 32'h0);
  endtask : t_eeprom
  task automatic t_flash();
    logic [31:0] q;
    logic saw;
    wr(ADDR_HIGH_OFS, 32'h0);
    wr(ADDR_LOW_OFS, 32'h40);
    unlock_trig(32'h96);
    wait_write(saw);
    chk({31'h0, saw}, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      if (i == 7)
      begin
        frd(8'h40, q);
        chk(q, 32'h3FFF);
      end
      wr(ADDR_LOW_OFS, 32'h40 + i);
      wr(DATA_LOW_OFS, 32'h10 + i);
      wr(DATA_HIGH_OFS, 32'h01);
      wr(STATUS_OFS, 32'h1);
      unlock_trig(i < 7 ? 32'hA6 : 32'h86);
      if (i < 7)
        chk({31'h0, stall}, 32'h0);
    end
    wr(CONTROL_OFS, 32'h80);
    wait_write(saw);
    chk({31'h0, saw}, 32'h1);
    rd(STATUS_OFS, q);
    chk(q & 32'h1, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      frd(8'h40 + 8'(i), q);
      chk(q, 32'h0110 + i);
    end
    wpf <= 2'b00;
    wr(ADDR_LOW_OFS, 32'h48);
    wr(DATA_LOW_OFS, 32'h00);
    wr(DATA_HIGH_OFS, 32'h00);
    unlock_trig(32'h86);
    wait_write(saw);
    frd(8'h48, q);
    chk(q, 32'h3FFF);
  endtask : t_flash
  task automatic t_wr_error();
    logic [31:0] q;
    @(posedge clk);
    rstn <= 1'b0;
    wip <= 1'b1;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(CONTROL_OFS, q);
    chk(q & 32'h8, 32'h8);
    chk({31'h0, done}, 32'h0);
    wip <= 1'b0;
    wr(CONTROL_OFS, 32'h0);
    rd(CONTROL_OFS, q);
    chk(q & 32'h8, 32'h0);
  endtask : t_wr_error
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #2000000;
    failures++;
    final_report();
  end
  initial
  begin
    rstn = 1'b0;
    wpf = 2'b11;
    cp = 1'b1;
    wip = 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_eeprom();
    t_flash();
    t_wr_error();
    final_report();
  end
endmodule : tb_top

// *** hdl/nvm_access_pkg.sv ***
// Package of register offsets, field positions and timing for the memory access controller.
package nvm_access_pkg;

  // ************************************************************
  // Register map (byte addresses on the APB bus)
  // ************************************************************
  localparam logic [7:0] ADDR_LOW_OFS = 8'h00;
  localparam logic [7:0] ADDR_HIGH_OFS = 8'h04;
  localparam logic [7:0] DATA_LOW_OFS = 8'h08;
  localparam logic [7:0] DATA_HIGH_OFS = 8'h0C;
  localparam logic [7:0] CONTROL_OFS = 8'h10;
  localparam logic [7:0] UNLOCK_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;

  // ************************************************************
  // Control and status register fields
  // ************************************************************
  localparam int CTL_READ_BIT = 0;
  localparam int CTL_WRITE_BIT = 1;
  localparam int CTL_PERMIT_BIT = 2;
  localparam int CTL_ERROR_BIT = 3;
  localparam int CTL_ERASE_BIT = 4;
  localparam int CTL_LATCH_BIT = 5;
  localparam int CTL_CFG_BIT = 6;
  localparam int CTL_PROG_BIT = 7;
  localparam int STS_DONE_BIT = 0;

  // ************************************************************
  // Unlock patterns, geometry, reset values and setup count
  // ************************************************************
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam int BLOCK_WORDS = 8;
  localparam int ROW_WORDS = 32;
  localparam int SETUP_CYCLES = 2;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int PROGRAM_TIME_US = 2000;
  localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * (CLK_HZ / 1_000_000);

  typedef enum logic [1:0] {
    UNLOCK_IDLE,
    UNLOCK_GOT_FIRST,
    UNLOCK_ARMED
  } unlock_e;

  typedef enum logic [2:0] {
    OP_IDLE,
    OP_SETUP,
    OP_BUSY,
    OP_FLASH_READ
  } op_e;

  typedef struct packed {
    logic prog;
    logic cfg;
    logic latch_only;
    logic erase;
    logic error;
    logic permit;
    logic write;
    logic read;
  } control_s;

endpackage : nvm_access_pkg

// *** hdl/self_program_memory_access.sv ***
// Self-programming controller for data EEPROM and flash program memory behind APB.
//
// Behaviour
// - EEPROM read with address low, selects clear, read trigger; byte next cycle.
// - Data low keeps read value until next read or software write.
// - EEPROM reads are allowed regardless of data code protect.
// - Byte write needs 55h, AAh to unlock port then write trigger, every byte.
// - Write trigger cannot be set while write permit is clear.
// - Clearing write permit does not stop a started write cycle.
// - Hardware never clears the write permit bit.
// - Write completion clears write trigger and sets the sticky write done flag.
// - Flash read uses second cycle after trigger; data in data low and high.
// - Flash erase is by 32-word rows aligned on low five address bits.
// - Row erase: program select, erase select, unlock patterns, write trigger.
// - Flash write performs no erase of its own.
// - Flash write only where the self-write-protect field leaves the segment open.
// - Flash programs eight-word aligned blocks and never crosses a block boundary.
// - Latch-only set: sequence stores data word into latch, no array program.
// - Latch-only clear: trigger loads last word then programs the whole block.
// - Two setup cycles follow the write trigger before erase or write.
// - Latch loads of the first seven words cause no processor stall.
// - Array erase or program halts the processor for typically 2 ms.
// - After programming, execution resumes at third instruction after the trigger.
// - Software only sets triggers; hardware clears them when done.
// - Reset during a write sets the write error flag.
//
// Added by the designer: the APB interface to the registers and the address map.
module self_program_memory_access
  import nvm_access_pkg::*;
#(
  parameter int EE_DEPTH = 256,
  parameter int FLASH_DEPTH = 4096,
  parameter int PROGRAM_CYCLES_P = PROGRAM_CYCLES
)
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [1:0] i_self_write_protect_field,
  input wire logic i_data_code_protect,
  input wire logic i_write_in_progress_at_reset,
  output logic o_cpu_stall,
  output logic o_write_done_flag
);

  // ************************************************************
  // Parameter checks
  // ************************************************************
  if (EE_DEPTH < 1 || EE_DEPTH > 256) $error("EE_DEPTH must be 1 to 256");
  if (FLASH_DEPTH < ROW_WORDS || FLASH_DEPTH > 32768) $error("FLASH_DEPTH out of range");
  if (PROGRAM_CYCLES_P < 1) $error("PROGRAM_CYCLES_P must be positive");

  localparam int FAW = $clog2(FLASH_DEPTH);

  // ************************************************************
  // State
  // ************************************************************
  logic [7:0] nvm_addr_low;
  logic [6:0] nvm_addr_high;
  logic [7:0] nvm_data_low;
  logic [5:0] nvm_data_high;
  control_s ctl;
  logic write_done_flag;
  unlock_e unlock_state;
  op_e op_state;
  logic [31:0] cnt;
  logic op_is_flash_prog;
  logic op_is_erase;
  logic op_is_ee;
  logic [7:0] ee_mem [EE_DEPTH];
  logic [13:0] flash_mem [FLASH_DEPTH];
  logic [13:0] latch [BLOCK_WORDS];
  logic [14:0] op_addr;
  // The byte to store is taken at the trigger so later data writes cannot alter it.
  logic [7:0] op_data;
  logic err_level;

  // ************************************************************
  // APB decode
  // ************************************************************
  logic wr_acc;
  logic rd_hit;
  logic known;
  logic [14:0] full_addr;
  logic [FAW-1:0] faddr;
  logic seg_open;
  logic trigger_ok;

  assign o_pready = 1'b1;
  assign wr_acc = i_psel && i_penable && i_pwrite;
  assign rd_hit = i_psel && i_penable && !i_pwrite;
  assign known = (i_paddr == ADDR_LOW_OFS) || (i_paddr == ADDR_HIGH_OFS) ||
                 (i_paddr == DATA_LOW_OFS) || (i_paddr == DATA_HIGH_OFS) ||
                 (i_paddr == CONTROL_OFS) || (i_paddr == UNLOCK_OFS) ||
                 (i_paddr == STATUS_OFS);
  assign o_pslverr = i_psel && i_penable && !known;
  assign full_addr = {nvm_addr_high, nvm_addr_low};
  assign faddr = full_addr[FAW-1:0];
  assign o_write_done_flag = write_done_flag;
  assign o_cpu_stall = (op_state == OP_BUSY) && !op_is_ee;

  // Protection: 00 protects all, 01 lower half, 10 lower quarter, 11 none.
  always_comb
  begin
    case (i_self_write_protect_field)
      2'b00: seg_open = 1'b0;
      2'b01: seg_open = faddr >= FAW'(FLASH_DEPTH / 2);
      2'b10: seg_open = faddr >= FAW'(FLASH_DEPTH / 4);
      default: seg_open = 1'b1;
    endcase
  end

  // A trigger write counts only when armed, permitted and idle.
  assign trigger_ok = wr_acc && (i_paddr == CONTROL_OFS) && i_pwdata[CTL_WRITE_BIT] &&
                      (unlock_state == UNLOCK_ARMED) && ctl.permit &&
                      (op_state == OP_IDLE) && !ctl.write;

  always_comb
  begin
    o_prdata = 32'h0000_0000;
    if (i_paddr == ADDR_LOW_OFS)
      o_prdata[7:0] = nvm_addr_low;
    else if (i_paddr == ADDR_HIGH_OFS)
      o_prdata[6:0] = nvm_addr_high;
    else if (i_paddr == DATA_LOW_OFS)
      o_prdata[7:0] = nvm_data_low;
    else if (i_paddr == DATA_HIGH_OFS)
      o_prdata[5:0] = nvm_data_high;
    else if (i_paddr == CONTROL_OFS)
    begin
      o_prdata[7:0] = ctl;
      o_prdata[CTL_ERROR_BIT] = ctl.error || err_level;
    end
    else if (i_paddr == STATUS_OFS)
      o_prdata[STS_DONE_BIT] = write_done_flag;
  end

  // ************************************************************
  // Unlock tracking
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      unlock_state <= UNLOCK_IDLE;
    else if (wr_acc && i_paddr == UNLOCK_OFS)
    begin
      if (unlock_state == UNLOCK_IDLE && i_pwdata[7:0] == UNLOCK_FIRST)
        unlock_state <= UNLOCK_GOT_FIRST;
      else if (unlock_state == UNLOCK_GOT_FIRST && i_pwdata[7:0] == UNLOCK_SECOND)
        unlock_state <= UNLOCK_ARMED;
      else
        unlock_state <= UNLOCK_IDLE;
    end
    else if (rd_hit && i_paddr == UNLOCK_OFS)
      unlock_state <= UNLOCK_IDLE;
    else if (wr_acc && i_paddr == CONTROL_OFS && i_pwdata[CTL_WRITE_BIT])
      unlock_state <= UNLOCK_IDLE;
    else if (wr_acc && unlock_state != UNLOCK_IDLE)
      unlock_state <= UNLOCK_IDLE;
  end

  // ************************************************************
  // Address registers
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      nvm_addr_low <= ADDR_RESET;
      nvm_addr_high <= ADDR_RESET[6:0];
    end
    else if (wr_acc && i_paddr == ADDR_LOW_OFS)
      nvm_addr_low <= i_pwdata[7:0];
    else if (wr_acc && i_paddr == ADDR_HIGH_OFS)
      nvm_addr_high <= i_pwdata[6:0];
  end

  // ************************************************************
  // Control register and operation sequencer
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctl <= CONTROL_RESET;
      op_state <= OP_IDLE;
      cnt <= 32'h0000_0000;
      op_is_flash_prog <= 1'b0;
      op_is_erase <= 1'b0;
      op_is_ee <= 1'b0;
      op_addr <= 15'h0000;
      op_data <= 8'h00;
    end
    else
    begin
      if (wr_acc && i_paddr == CONTROL_OFS)
      begin
        ctl.prog <= i_pwdata[CTL_PROG_BIT];
        ctl.cfg <= i_pwdata[CTL_CFG_BIT];
        ctl.latch_only <= i_pwdata[CTL_LATCH_BIT];
        ctl.erase <= i_pwdata[CTL_ERASE_BIT];
        ctl.permit <= i_pwdata[CTL_PERMIT_BIT];
        ctl.error <= i_pwdata[CTL_ERROR_BIT];
        if (i_pwdata[CTL_READ_BIT] && op_state == OP_IDLE && !i_pwdata[CTL_CFG_BIT])
        begin
          if (i_pwdata[CTL_PROG_BIT])
          begin
            ctl.read <= 1'b1;
            op_state <= OP_FLASH_READ;
          end
        end
        if (trigger_ok)
        begin
          ctl.write <= 1'b1;
          op_addr <= full_addr;
          op_data <= nvm_data_low;
          op_is_ee <= !ctl.prog;
          op_is_erase <= ctl.prog && ctl.erase;
          op_is_flash_prog <= ctl.prog && !ctl.erase && !ctl.latch_only;
          op_state <= OP_SETUP;
          cnt <= 32'h0000_0000;
        end
      end
      case (op_state)
        OP_FLASH_READ:
        begin
          ctl.read <= 1'b0;
          op_state <= OP_IDLE;
        end
        OP_SETUP:
        begin
          if (cnt == 32'(SETUP_CYCLES - 1))
          begin
            cnt <= 32'h0000_0000;
            if (op_is_ee || op_is_erase || op_is_flash_prog)
              op_state <= OP_BUSY;
            else
            begin
              ctl.write <= 1'b0;
              op_state <= OP_IDLE;
            end
          end
          else
            cnt <= cnt + 32'h0000_0001;
        end
        OP_BUSY:
        begin
          if (cnt == 32'(PROGRAM_CYCLES_P - 1))
          begin
            ctl.write <= 1'b0;
            op_state <= OP_IDLE;
          end
          else
            cnt <= cnt + 32'h0000_0001;
        end
        default:
        begin
          cnt <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ************************************************************
  // Write error flag
  // ************************************************************
  // Write error is caught after release from the reset-time write-in-progress level.
  logic error_seen;
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      error_seen <= 1'b0;
    else
      error_seen <= 1'b1;
  end

  // ************************************************************
  // Write done flag: set wins over software clear
  // ************************************************************
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      write_done_flag <= 1'b0;
    else if (op_state == OP_BUSY && cnt == 32'(PROGRAM_CYCLES_P - 1))
      write_done_flag <= 1'b1;
    else if (op_state == OP_SETUP && cnt == 32'(SETUP_CYCLES - 1) &&
             !(op_is_ee || op_is_erase || op_is_flash_prog))
      write_done_flag <= 1'b1;
    else if (wr_acc && i_paddr == STATUS_OFS && i_pwdata[STS_DONE_BIT])
      write_done_flag <= 1'b0;
  end

  // ************************************************************
  // Data registers and memory arrays
  // ************************************************************
  logic ee_read_now;
  logic [7:0] ee_idx;
  logic [2:0] blk_idx;
  logic [FAW-1:0] op_faddr;

  assign ee_read_now = wr_acc && (i_paddr == CONTROL_OFS) && i_pwdata[CTL_READ_BIT] &&
                       !i_pwdata[CTL_PROG_BIT] && !i_pwdata[CTL_CFG_BIT] &&
                       (op_state == OP_IDLE);
  assign ee_idx = nvm_addr_low;
  assign blk_idx = nvm_addr_low[2:0];
  assign op_faddr = op_addr[FAW-1:0];

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      nvm_data_low <= 8'h00;
      nvm_data_high <= 6'h00;
    end
    else if (ee_read_now)
      nvm_data_low <= (32'(ee_idx) < EE_DEPTH) ? ee_mem[ee_idx] : 8'h00;
    else if (op_state == OP_FLASH_READ)
    begin
      nvm_data_low <= flash_mem[faddr][7:0];
      nvm_data_high <= flash_mem[faddr][13:8];
    end
    else if (wr_acc && i_paddr == DATA_LOW_OFS)
      nvm_data_low <= i_pwdata[7:0];
    else if (wr_acc && i_paddr == DATA_HIGH_OFS)
      nvm_data_high <= i_pwdata[5:0];
  end

  // Latches take the current word at every accepted flash trigger that is not an erase.
  always_ff @(posedge i_clk)
  begin
    if (trigger_ok && ctl.prog && !ctl.erase)
      latch[blk_idx] <= {nvm_data_high, nvm_data_low};
  end

  always_ff @(posedge i_clk)
  begin
    if (op_state == OP_BUSY && cnt == 32'(PROGRAM_CYCLES_P - 1))
    begin
      if (op_is_ee && 32'(op_addr[7:0]) < EE_DEPTH)
        ee_mem[op_addr[7:0]] <= op_data;
      else if (op_is_erase && seg_open)
      begin
        for (int i = 0; i < ROW_WORDS; i++)
          flash_mem[{op_faddr[FAW-1:5], 5'(i)}] <= 14'h3FFF;
      end
      else if (op_is_flash_prog && seg_open)
      begin
        for (int i = 0; i < BLOCK_WORDS; i++)
          flash_mem[{op_faddr[FAW-1:3], 3'(i)}] <=
            flash_mem[{op_faddr[FAW-1:3], 3'(i)}] & latch[i];
      end
    end
  end

  // Error flag reads as set after a reset that cut a write short.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      err_level <= 1'b0;
    else if (!error_seen && i_write_in_progress_at_reset)
      err_level <= 1'b1;
    else if (wr_acc && i_paddr == CONTROL_OFS && !i_pwdata[CTL_ERROR_BIT])
      err_level <= 1'b0;
  end

endmodule : self_program_memory_access
